// File: hw/ecm_extend.sv
// Overview of operation
// (RQ1) Leaf code 06H under the privileged opcode measures a 256-byte chunk.
// (RQ2) Runs only at privilege level 0 on an uninitialised enclave.
// (RQ3) Structure pointer not 4096-byte aligned gives protection fault, code 0.
// (RQ4) Structure pointer outside the protected page cache gives page fault.
// (RQ5) Chunk pointer not 256-byte aligned gives protection fault, code 0.
// (RQ6) Chunk pointer outside the protected page cache gives page fault.
// (RQ7) Concurrent metadata table access gives protection fault, code 0.
// (RQ8) Chunk page metadata invalid gives page fault on chunk pointer.
// (RQ9) Chunk page type not regular, thread or shadow stack: page fault.
// (RQ10) Structure pointer not owning chunk page gives protection fault.
// (RQ11) Concurrent measurement or init-state access gives protection fault.
// (RQ12) Already initialised enclave gives protection fault, no measurement.
// (RQ13) Offset is page address minus base plus chunk pointer low 12 bits.
// (RQ14) Hash header block with tag and offset, counter plus one.
// (RQ15) Hash four 64-byte chunk blocks lowest first, counter plus four.
// (RQ16) Linear addresses use data segment base only, no override.
// (RQ17) Non-canonical pointer in 64-bit mode, else limit overrun: fault.
// (RQ18) Shared chunk page access conflict gives protection fault.
// (RQ19) All checks precede hashing; a fault commits nothing.
// (RQ20) Arithmetic status flags are never written.
`timescale 1ns/1ps
`default_nettype none
module ecm_extend
  import ecm_pkg::*;
#(
  parameter int VA_BITS = 48
)(
  input  wire logic         ref_clk_i,            // Core clock, 40 MHz
  input  wire logic         reset_i,              // Sync reset, high
  input  wire logic         start_i,              // Issue pulse
  input  wire logic         priv_opcode_i,        // privileged_enclave_opcode
  input  wire logic [31:0]  leaf_selector_i,      // Leaf code
  input  wire logic [1:0]   cpl_i,                // current_privilege_level
  input  wire logic         mode64_i,             // 64-bit mode
  input  wire logic [63:0]  ctl_ptr_i,            // control_structure_pointer
  input  wire logic [63:0]  chunk_ptr_i,          // chunk_pointer
  input  wire logic [63:0]  ds_base_i,            // Data segment base
  input  wire logic [31:0]  ds_limit_i,           // Data segment limit
  input  wire logic         ctl_in_ppc_i,         // Structure page in cache
  input  wire logic         chunk_in_ppc_i,       // Chunk in cache
  input  wire logic         table_busy_i,         // Metadata table in use
  input  wire logic         meta_valid_i,         // Chunk page valid bit
  input  wire logic [7:0]   meta_type_i,          // Chunk page type
  input  wire logic [63:0]  meta_owner_i,         // Owning structure addr
  input  wire logic [63:0]  meta_enclave_addr_i,  // Page enclave address
  input  wire logic [63:0]  enclave_control_structure_base_i,          // Enclave base address
  input  wire logic         enclave_control_structure_init_i,          // Enclave initialised
  input  wire logic         meas_busy_i,          // Measurement in use
  input  wire logic         chunk_conflict_i,     // Shared access refused
  output logic              rd_req_o,             // Chunk block read
  output logic [63:0]       rd_addr_o,            // Block linear address
  input  wire logic         rd_valid_i,           // Read data valid
  input  wire logic [511:0] rd_data_i,            // Read data
  output logic              hash_valid_o,         // Block to hash core
  output logic [511:0]      hash_block_o,         // Hash block
  input  wire logic         hash_ready_i,         // Hash core takes block
  output logic              ctr_inc_o,            // Counter advance pulse
  output logic [2:0]        ctr_amt_o,            // Counter step
  output logic              busy_o,               // Operation in flight
  output logic              done_o,               // Completion pulse
  output logic              gp_o,                 // general_protection_fault
  output logic              pf_o,                 // page_fault
  output logic [63:0]       pf_addr_o,            // Faulting linear address
  output logic [15:0]       err_code_o,           // Fault error code
  output logic              flags_we_o,           // Status flag write
  output logic [63:0]       ctl_lin_o,            // Structure lookup addr
  output logic [63:0]       chunk_lin_o           // Chunk lookup addr
);

  if (VA_BITS < 32 || VA_BITS > 63)
  begin : g_bad_va
    $error("VA_BITS out of range");
  end

  typedef struct packed {
    ecm_state_t   st;
    logic         pre_gp;
    logic [63:0]  ctl_lin;
    logic [63:0]  chk_lin;
    logic [1:0]   idx;
    logic         rd_req;
    logic [63:0]  rd_addr;
    logic         hash_valid;
    logic [511:0] hash_block;
    logic         ctr_inc;
    logic [2:0]   ctr_amt;
    logic         busy;
    logic         done;
    logic         gp;
    logic         pf;
    logic [63:0]  pf_addr;
    logic         flags_we;
  } ecm_reg_t;

  ecm_reg_t q;
  ecm_reg_t d;

  logic        accept;
  logic        type_ok;
  logic        range_bad;
  logic [63:0] ofs;

  function automatic logic noncanon(input logic [63:0] p);
    logic [63:0] s;
    s = 64'($signed(p) >>> (VA_BITS - 1));
    return !(s == 64'h0000_0000_0000_0000 ||
             s == 64'hFFFF_FFFF_FFFF_FFFF);
  endfunction : noncanon

  function automatic logic over_limit(input logic [63:0] p,
                                      input logic [31:0] lim);
    return (p[63:32] != 32'h0000_0000) || (p[31:0] > lim);
  endfunction : over_limit

  // (RQ1) leaf code decode
  assign accept = start_i && priv_opcode_i && (q.st == ST_IDLE) &&
                  (leaf_selector_i == LEAF_CHUNK_MEASURE);

  // (RQ17) canonical or limit check
  assign range_bad = mode64_i ?
    (noncanon(ctl_ptr_i) || noncanon(chunk_ptr_i)) :
    (over_limit(ctl_ptr_i, ds_limit_i) ||
     over_limit(chunk_ptr_i, ds_limit_i));

  // (RQ9) accepted page types
  assign type_ok = (meta_type_i == regular_page_type) ||
                   (meta_type_i == thread_control_page_type) ||
                   (meta_type_i == first_shadow_stack_page_type) ||
                   (meta_type_i == later_shadow_stack_page_type);

  // (RQ13) enclave offset
  assign ofs = meta_enclave_addr_i - enclave_control_structure_base_i +
               (q.chk_lin & PAGE_OFS_MASK);

  always_comb
  begin
    d          = q;
    d.ctr_inc  = 1'b0;
    d.done     = 1'b0;
    d.gp       = 1'b0;
    d.pf       = 1'b0;
    // (RQ20) flags never written
    d.flags_we = 1'b0;
    case (q.st)
      ST_IDLE:
      begin
        d.pf_addr = 64'h0000_0000_0000_0000;
        if (accept)
        begin
          // (RQ16) data segment base only
          d.ctl_lin = ds_base_i + ctl_ptr_i;
          d.chk_lin = ds_base_i + chunk_ptr_i;
          // (RQ2) privilege level gate
          d.pre_gp  = range_bad || (cpl_i != CPL_KERNEL);
          d.busy    = 1'b1;
          d.st      = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        // (RQ19) faults resolved before hashing
        d.st   = ST_DONE;
        d.done = 1'b1;
        if (q.pre_gp)
          d.gp = 1'b1;
        // (RQ3) structure alignment
        else if ((q.ctl_lin & CTL_ALIGN_MASK) != 64'h0)
          d.gp = 1'b1;
        // (RQ4) structure page lookup
        else if (!ctl_in_ppc_i)
        begin
          d.pf      = 1'b1;
          d.pf_addr = q.ctl_lin;
        end
        // (RQ5) chunk alignment
        else if ((q.chk_lin & CHUNK_ALIGN_MASK) != 64'h0)
          d.gp = 1'b1;
        // (RQ6) chunk page lookup
        else if (!chunk_in_ppc_i)
        begin
          d.pf      = 1'b1;
          d.pf_addr = q.chk_lin;
        end
        // (RQ7) metadata table busy
        else if (table_busy_i)
          d.gp = 1'b1;
        // (RQ8) invalid chunk page, (RQ9) wrong page type
        else if (!meta_valid_i || !type_ok)
        begin
          d.pf      = 1'b1;
          d.pf_addr = q.chk_lin;
        end
        // (RQ10) owner mismatch
        else if (meta_owner_i != q.ctl_lin)
          d.gp = 1'b1;
        // (RQ11) measurement busy
        else if (meas_busy_i)
          d.gp = 1'b1;
        // (RQ12) already initialised
        else if (enclave_control_structure_init_i)
          d.gp = 1'b1;
        // (RQ18) shared access conflict
        else if (chunk_conflict_i)
          d.gp = 1'b1;
        else
        begin
          // (RQ14) header block
          d.done       = 1'b0;
          d.hash_block = {384'h0, ofs, HDR_TAG};
          d.hash_valid = 1'b1;
          d.st         = ST_HDR;
        end
      end
      ST_HDR:
      begin
        if (hash_ready_i)
        begin
          // (RQ14) counter plus one
          d.hash_valid = 1'b0;
          d.ctr_inc    = 1'b1;
          d.ctr_amt    = CTR_HDR_STEP;
          d.idx        = 2'h0;
          d.rd_req     = 1'b1;
          d.rd_addr    = q.chk_lin;
          d.st         = ST_RD;
        end
      end
      ST_RD:
      begin
        if (rd_valid_i)
        begin
          d.rd_req     = 1'b0;
          d.hash_block = rd_data_i;
          d.hash_valid = 1'b1;
          d.st         = ST_BLK;
        end
      end
      ST_BLK:
      begin
        if (hash_ready_i)
        begin
          d.hash_valid = 1'b0;
          // (RQ15) four blocks then counter plus four
          if (q.idx == LAST_BLK)
          begin
            d.ctr_inc = 1'b1;
            d.ctr_amt = CTR_CHUNK_STEP;
            d.done    = 1'b1;
            d.st      = ST_DONE;
          end
          else
          begin
            d.idx     = q.idx + 2'h1;
            d.rd_req  = 1'b1;
            d.rd_addr = q.chk_lin + {56'h0, q.idx + 2'h1, 6'h00};
            d.st      = ST_RD;
          end
        end
      end
      ST_DONE:
      begin
        d.busy = 1'b0;
        d.st   = ST_IDLE;
      end
      default:
      begin
        d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      q         <= '0;
      q.st      <= ST_IDLE;
      q.ctr_amt <= CTR_HDR_STEP;
    end
    else
      q <= d;
  end

  assign rd_req_o     = q.rd_req;
  assign rd_addr_o    = q.rd_addr;
  assign hash_valid_o = q.hash_valid;
  assign hash_block_o = q.hash_block;
  assign ctr_inc_o    = q.ctr_inc;
  assign ctr_amt_o    = q.ctr_amt;
  assign busy_o       = q.busy;
  assign done_o       = q.done;
  assign gp_o         = q.gp;
  assign pf_o         = q.pf;
  assign pf_addr_o    = q.pf_addr;
  // (RQ3) error code zero
  assign err_code_o   = GP_ERR_CODE;
  assign flags_we_o   = q.flags_we;
  assign ctl_lin_o    = q.ctl_lin;
  assign chunk_lin_o  = q.chk_lin;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  a_cpl_gate: assert property ( // RQ2
    accept && cpl_i != CPL_KERNEL |-> ##2 done_o && gp_o && !pf_o)
    else $error("privilege fault missing");

  a_ctl_align: assert property ( // RQ3
    accept && cpl_i == CPL_KERNEL && !range_bad &&
    ((ds_base_i + ctl_ptr_i) & CTL_ALIGN_MASK) != 64'h0
    |-> ##2 gp_o && done_o)
    else $error("structure alignment fault missing");

  a_fault_nohash: assert property ( // RQ19
    done_o && (gp_o || pf_o) |-> $past(q.st) == ST_CHECK && !ctr_inc_o)
    else $error("fault after hashing began");

  a_hdr_tag: assert property ( // RQ14
    q.st == ST_HDR |-> hash_valid_o && hash_block_o[63:0] == HDR_TAG &&
    hash_block_o[511:128] == 384'h0)
    else $error("bad header block");

  a_hdr_offset: assert property ( // RQ13
    q.st == ST_HDR && $past(q.st) == ST_CHECK |-> hash_block_o[127:64] ==
      $past(meta_enclave_addr_i) - $past(enclave_control_structure_base_i) +
      (q.chk_lin & PAGE_OFS_MASK))
    else $error("bad enclave offset");

  a_hdr_checks: assert property ( // RQ12
    q.st == ST_HDR && $past(q.st) == ST_CHECK
    |-> $past(meta_valid_i && !enclave_control_structure_init_i && !table_busy_i &&
                       !meas_busy_i && !chunk_conflict_i && type_ok))
    else $error("hash started despite failed check");

  a_ctr_four: assert property ( // RQ15
    ctr_inc_o && ctr_amt_o == CTR_CHUNK_STEP
    |-> $past(q.st) == ST_BLK && $past(q.idx) == LAST_BLK && done_o)
    else $error("counter step four out of place");

  a_rd_addr: assert property ( // RQ15
    rd_req_o |-> rd_addr_o == q.chk_lin + {56'h0, q.idx, 6'h00})
    else $error("chunk block address wrong");

  a_pf_addr: assert property ( // RQ6
    pf_o |-> pf_addr_o == q.ctl_lin || pf_addr_o == q.chk_lin)
    else $error("page fault address wrong");

  a_flags_hold: assert property ( // RQ20
    !flags_we_o)
    else $error("status flags written");

  a_issue_busy: assert property ( // RQ1
    accept |=> busy_o && q.st == ST_CHECK)
    else $error("issue not taken");

  a_seg_base: assert property ( // RQ16
    accept |=> ctl_lin_o == $past(ds_base_i) + $past(ctl_ptr_i) &&
      chunk_lin_o == $past(ds_base_i) + $past(chunk_ptr_i))
    else $error("linear address not from data segment");

  a_chunk_align: assert property ( // RQ5
    q.st == ST_CHECK && !q.pre_gp &&
    (q.ctl_lin & CTL_ALIGN_MASK) == 64'h0 && ctl_in_ppc_i &&
    (q.chk_lin & CHUNK_ALIGN_MASK) != 64'h0 |=> gp_o && done_o)
    else $error("chunk alignment fault missing");

  a_canon_gate: assert property ( // RQ17
    accept && mode64_i && noncanon(ctl_ptr_i) |-> ##2 gp_o && done_o)
    else $error("non-canonical pointer fault missing");

  c_success: cover property (done_o && !gp_o && !pf_o);
  c_gp: cover property (done_o && gp_o);
  c_pf: cover property (done_o && pf_o);
  c_stall: cover property (hash_valid_o && !hash_ready_i [*2]);
  c_slow_read: cover property (rd_req_o && !rd_valid_i [*2]);

endmodule : ecm_extend
`default_nettype wire

// File: hw/ecm_pkg.sv
package ecm_pkg;
  localparam logic [31:0]  LEAF_CHUNK_MEASURE = 32'h0000_0006;
  localparam logic [63:0]  CTL_ALIGN_MASK     = 64'h0000_0000_0000_0FFF;
  localparam logic [63:0]  CHUNK_ALIGN_MASK   = 64'h0000_0000_0000_00FF;
  localparam logic [63:0]  PAGE_OFS_MASK      = 64'h0000_0000_0000_0FFF;
  localparam logic [63:0]  HDR_TAG            = 64'h0044_4E45_5458_4545;
  localparam logic [63:0]  BLK_BYTES          = 64'h0000_0000_0000_0040;
  localparam logic [1:0]   LAST_BLK           = 2'h3;
  localparam logic [2:0]   CTR_HDR_STEP       = 3'h1;
  localparam logic [2:0]   CTR_CHUNK_STEP     = 3'h4;
  localparam logic [15:0]  GP_ERR_CODE        = 16'h0000;
  localparam logic [1:0]   CPL_KERNEL         = 2'h0;
  // Page type encodings of the metadata store
  localparam logic [7:0]   regular_page_type            = 8'h01;
  localparam logic [7:0]   thread_control_page_type     = 8'h02;
  localparam logic [7:0]   first_shadow_stack_page_type = 8'h03;
  localparam logic [7:0]   later_shadow_stack_page_type = 8'h04;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CHECK = 3'h1,
    ST_HDR   = 3'h3,
    ST_RD    = 3'h2,
    ST_BLK   = 3'h6,
    ST_DONE  = 3'h7
  } ecm_state_t;
endpackage : ecm_pkg

// File: tb/ecm_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecm_far_model
(
  input  wire logic         ref_clk_i,    // Core clock
  input  wire logic         reset_i,      // Sync reset, high
  input  wire logic         slow_i,       // Answer after three waits
  input  wire logic         rd_req_i,     // Block read request
  input  wire logic [63:0]  rd_addr_i,    // Block address
  output logic              rd_valid_o,   // Read data valid pulse
  output logic [511:0]      rd_data_o,    // Read data
  input  wire logic         hash_valid_i, // Block offered
  output logic              hash_ready_o  // Block taken pulse
);
  logic [1:0] wait_q;
  logic       rd_pend;
  logic       hs_pend;

  assign rd_pend = rd_req_i && !rd_valid_o;
  assign hs_pend = hash_valid_i && !hash_ready_o;

  always_ff @(posedge ref_clk_i)
  begin
    rd_valid_o   <= 1'b0;
    hash_ready_o <= 1'b0;
    // Stale read data toggles between the last block and its inverse each cycle
    rd_data_o    <= ~rd_data_o;
    if (reset_i)
    begin
      wait_q    <= 2'h0;
      rd_data_o <= '0;
    end
    else if ((rd_pend || hs_pend) && (!slow_i || wait_q == 2'h3))
    begin
      wait_q       <= 2'h0;
      rd_valid_o   <= rd_pend;
      hash_ready_o <= !rd_pend;
      if (rd_pend)
        rd_data_o <= {4{rd_addr_i, ~rd_addr_i}};
    end
    else if (rd_pend || hs_pend)
      wait_q <= wait_q + 2'h1;
  end
endmodule : ecm_far_model
`default_nettype wire

// File: tb/enclave_chunk_measure_extend_test.sv
`timescale 1ns/1ps
`default_nettype none
module enclave_chunk_measure_extend_test;
  import ecm_pkg::*;
  logic         ref_clk_i, reset_i, start_i, priv_opcode_i, mode64_i;
  logic         ctl_in_ppc_i, chunk_in_ppc_i, table_busy_i, meta_valid_i;
  logic         enclave_control_structure_init_i, meas_busy_i, chunk_conflict_i, slow, pf;
  logic         rd_req_o, rd_valid_i, hash_valid_o, hash_ready_i, ctr_inc_o;
  logic         busy_o, done_o, gp_o, pf_o, flags_we_o, flag_seen;
  logic [31:0]  leaf_selector_i, ds_limit_i;
  logic [1:0]   cpl_i;
  logic [7:0]   meta_type_i;
  logic [2:0]   ctr_amt_o;
  logic [15:0]  err_code_o;
  logic [63:0]  ctl_ptr_i, chunk_ptr_i, ds_base_i, meta_owner_i, enclave_control_structure_base_i;
  logic [63:0]  meta_enclave_addr_i, pf_addr_o, ctl_lin_o, chunk_lin_o;
  logic [63:0]  rd_addr_o, lin, bv, cv, kv;
  logic [511:0] rd_data_i, hash_block_o;
  logic [511:0] blk_q[$];
  logic [63:0]  adr_q[$];
  logic [2:0]   amt_q[$];
  int           fail_count, checks_done, seed, cyc;

  ecm_extend DUT (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .start_i(start_i),
    .priv_opcode_i(priv_opcode_i), .leaf_selector_i(leaf_selector_i),
    .cpl_i(cpl_i), .mode64_i(mode64_i), .ctl_ptr_i(ctl_ptr_i),
    .chunk_ptr_i(chunk_ptr_i), .ds_base_i(ds_base_i),
    .ds_limit_i(ds_limit_i), .ctl_in_ppc_i(ctl_in_ppc_i),
    .chunk_in_ppc_i(chunk_in_ppc_i), .table_busy_i(table_busy_i),
    .meta_valid_i(meta_valid_i), .meta_type_i(meta_type_i),
    .meta_owner_i(meta_owner_i),
    .meta_enclave_addr_i(meta_enclave_addr_i),
    .enclave_control_structure_base_i(enclave_control_structure_base_i), .enclave_control_structure_init_i(enclave_control_structure_init_i),
    .meas_busy_i(meas_busy_i), .chunk_conflict_i(chunk_conflict_i),
    .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_valid_i(rd_valid_i),
    .rd_data_i(rd_data_i), .hash_valid_o(hash_valid_o),
    .hash_block_o(hash_block_o), .hash_ready_i(hash_ready_i),
    .ctr_inc_o(ctr_inc_o), .ctr_amt_o(ctr_amt_o), .busy_o(busy_o),
    .done_o(done_o), .gp_o(gp_o), .pf_o(pf_o), .pf_addr_o(pf_addr_o),
    .err_code_o(err_code_o), .flags_we_o(flags_we_o),
    .ctl_lin_o(ctl_lin_o), .chunk_lin_o(chunk_lin_o));

  ecm_far_model far (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .slow_i(slow), .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o),
    .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i),
    .hash_valid_i(hash_valid_o), .hash_ready_o(hash_ready_i));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
  begin
    if (hash_valid_o === 1'b1 && hash_ready_i === 1'b1)
      blk_q.push_back(hash_block_o);
    if (rd_req_o === 1'b1 && rd_valid_i === 1'b1)
      adr_q.push_back(rd_addr_o);
    if (ctr_inc_o === 1'b1)
      amt_q.push_back(ctr_amt_o);
    if (flags_we_o !== 1'b0)
      flag_seen = 1'b1;
  end

  function automatic logic [511:0] hdr(input logic [63:0] ea, sb, ln);
    hdr = {384'h0, ea - sb + (ln & 64'h0FFF), 64'h0044_4E45_5458_4545};
  endfunction : hdr

  task automatic cmp_val(input string nm, input logic [63:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_val

  task automatic cmp_blk(input string nm, input logic [511:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_blk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic setup(input logic m64, input logic [7:0] t);
    bv = {40'h0, 12'($random(seed)), 12'h000};
    cv = {40'h0, 12'($random(seed)), 12'h000};
    kv = {40'h0, 16'($random(seed)), 8'h00};
    ds_base_i           <= bv;
    ctl_ptr_i           <= cv;
    chunk_ptr_i         <= kv;
    meta_owner_i        <= bv + cv;
    meta_enclave_addr_i <= {$random(seed), $random(seed)};
    enclave_control_structure_base_i         <= {$random(seed), $random(seed)};
    meta_type_i         <= t;
    mode64_i            <= m64;
    ds_limit_i          <= 32'hFFFF_FFFF;
    cpl_i               <= 2'h0;
    leaf_selector_i     <= 32'h0000_0006;
    priv_opcode_i       <= 1'b1;
    {ctl_in_ppc_i, chunk_in_ppc_i, meta_valid_i} <= 3'h7;
    {table_busy_i, meas_busy_i, enclave_control_structure_init_i, chunk_conflict_i} <= 4'h0;
    blk_q.delete();
    adr_q.delete();
    amt_q.delete();
    flag_seen = 1'b0;
  endtask : setup

  task automatic op(output int n);
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    n = 0;
    #1;
    while (done_o !== 1'b1)
    begin
      if (n == 300)
      begin
        fail_count++;
        $display("ERROR done_o expected 1 seen timeout");
        complete_run();
      end
      @(posedge ref_clk_i);
      #1;
      n++;
    end
  endtask : op

  initial
  begin
    seed = 4795;
    fail_count = 0;
    checks_done = 0;
    reset_i = 1'b1;
    start_i = 1'b0;
    slow = 1'b0;
    setup(1'b1, 8'h01);
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk_i);
      setup(i[0], 8'(i % 4 + 1));
      slow <= i[1];
      op(cyc);
      lin = ds_base_i + chunk_ptr_i;
      cmp_val("gp_pf", 0, {gp_o, pf_o});
      cmp_val("ctl_lin_o", ds_base_i + ctl_ptr_i, ctl_lin_o);
      cmp_val("chunk_lin_o", lin, chunk_lin_o);
      @(posedge ref_clk_i);
      #1;
      cmp_val("busy_o", 0, busy_o);
      cmp_val("queues", 64'h0005_0004_0002, {16'(blk_q.size()),
        16'(adr_q.size()), 16'(amt_q.size())});
      if (blk_q.size() == 5 && adr_q.size() == 4 && amt_q.size() == 2)
      begin
        cmp_blk("header", hdr(meta_enclave_addr_i, enclave_control_structure_base_i, lin),
          blk_q[0]);
        cmp_val("amt_hdr", 1, amt_q[0]);
        cmp_val("amt_chunk", 4, amt_q[1]);
        for (int j = 0; j < 4; j++)
        begin
          cmp_val("rd_addr_o", lin + 64 * j, adr_q[j]);
          cmp_blk("chunk", {4{lin + 64 * j, ~(lin + 64 * j)}},
            blk_q[j + 1]);
        end
      end
      cmp_val("flags", 0, flag_seen);
    end
    $display("success runs ended");
    for (int k = 0; k < 15; k++)
    begin
      @(posedge ref_clk_i);
      setup(k != 14, 8'h02);
      slow <= k[0];
      @(posedge ref_clk_i);
      pf = (k == 2 || k == 4 || k == 6 || k == 7 || k == 8);
      case (k)
        0: cpl_i <= 2'h3;
        1: cv = cv | 64'h0800;
        2: ctl_in_ppc_i <= 1'b0;
        3: kv = kv | 64'h0040;
        4: chunk_in_ppc_i <= 1'b0;
        5: table_busy_i <= 1'b1;
        6: meta_valid_i <= 1'b0;
        7: meta_type_i <= 8'h00;
        8: meta_type_i <= 8'h05;
        10: meas_busy_i <= 1'b1;
        11: enclave_control_structure_init_i <= 1'b1;
        12: chunk_conflict_i <= 1'b1;
        13: cv = cv | 64'h0004_0000_0000_0000;
        14:
        begin
          kv = kv | 64'h0100;
          ds_limit_i <= 32'h0;
        end
        default: ;
      endcase
      ctl_ptr_i <= cv;
      chunk_ptr_i <= kv;
      meta_owner_i <= (k == 9) ? ~(bv + cv) : bv + cv;
      op(cyc);
      cmp_val("done_delay", 1, 64'(cyc));
      cmp_val("gp_o", !pf, gp_o);
      cmp_val("pf_o", pf, pf_o);
      cmp_val("err_code_o", 0, err_code_o);
      if (pf)
        cmp_val("pf_addr_o", bv + ((k == 2) ? cv : kv), pf_addr_o);
      @(posedge ref_clk_i);
      #1;
      cmp_val("no_update", 0, {blk_q.size(), amt_q.size()});
    end
    $display("fault runs ended");
    for (int l = 0; l < 9; l++)
    begin
      @(posedge ref_clk_i);
      setup(1'b1, 8'h01);
      @(posedge ref_clk_i);
      leaf_selector_i <= (l == 6) ? 32'h16 : (l == 8) ? 32'h6 : 32'(l);
      priv_opcode_i <= (l != 8);
      @(posedge ref_clk_i);
      start_i <= 1'b1;
      @(posedge ref_clk_i);
      start_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
      cmp_val("busy_o", 0, busy_o);
    end
    $display("ignored issue runs ended");
    complete_run();
  end
endmodule : enclave_chunk_measure_extend_test
`default_nettype wire
